// *** logic/radio_freq_power_config.sv ***
// Overview of operation
// - threshold flag high while fifo byte count is at or above threshold
// - 4-bit threshold code: 61 bytes at code 0, four fewer per step
// - output selector 0x02 shows the fifo threshold flag
// - channel spacing held as mantissa and exponent fields
// - 24-bit base frequency word in high, middle and low bytes
// - 8-bit channel number scales the per-channel offset
// - carrier word = base + channel_index*(256+mantissa)*2^(exp-2), units fxosc/2^16
// - intermediate frequency word is the programmed field, units fxosc/2^10
// - calibrate after power-up; optional auto calibration at start or end
// - calibrate strobe in idle starts a manual calibration
// - calibration values survive sleep
// - output selector 0x0A shows the pll lock detector
// - calibration result reads other than 0x3F when locked
// - chip select low powers up; host waits for serial output low
// - after power-down strobe, sleep when chip select rises, wake on fall
// - two power table entries; power select 1 keys them per data bit, any other select uses entry 0
// - on-off keying picks entry 0 or 1 per data bit
// - first power table entry resets to 0xC6
// - sleep loses every power entry except entry 0
`timescale 1ns/1ps
`include "rf_cfg_defs.svh"

module radio_freq_power_config
  import rf_cfg_pkg::*;
#(
  parameter int CAL_CYCLES = `CAL_CYCLES_DEF
)
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // four-wire serial port
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  // synthesizer and transmit path
  input wire logic pll_lock,
  input wire logic [5:0] vco_cal_code,
  input wire logic [6:0] fifo_count,
  input wire logic tx_packet_done,
  input wire logic tx_data_bit,
  output logic [26:0] carrier_word,
  output logic [4:0] if_word,
  output logic [7:0] pa_setting,
  output logic synth_en,
  output logic core_power_en,
  // general outputs
  output logic [2:0] general_output_pin,
  output logic [2:0] general_output_oe_n
);

  function automatic logic [7:0] read_byte(input snap_t s, input logic [5:0] a, input logic idx);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `A_PIN_CFG0: r = {1'b0, s.cfg.pin_cfg[0]};
      `A_PIN_CFG1: r = {1'b0, s.cfg.pin_cfg[1]};
      `A_PIN_CFG2: r = {1'b0, s.cfg.pin_cfg[2]};
      `A_FIFO_THRESHOLD_CODE: r = {4'h0, s.cfg.fifo_threshold_code};
      `A_CHANNEL_INDEX: r = s.cfg.channel_index;
      `A_SYNTH_CTRL: r = {3'h0, s.cfg.if_field};
      `A_FREQ_HI: r = s.cfg.base_freq[23:16];
      `A_FREQ_MID: r = s.cfg.base_freq[15:8];
      `A_FREQ_LO: r = s.cfg.base_freq[7:0];
      `A_MDM_HI: r = {6'h00, s.cfg.exponent};
      `A_MDM_LO: r = s.cfg.mantissa;
      `A_SM_CFG: r = {2'h0, s.cfg.auto_cal, 4'h0};
      `A_FRONT_END: r = {5'h00, s.cfg.pa_sel};
      `A_CAL_RESULT: r = {2'h0, s.cal_result};
      `A_PA_TABLE: r = s.cfg.pa_table[idx];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic pin_func(input logic [5:0] sel, input logic thr, input logic lock,
                                    input logic rdy_n);
    logic v;
    v = 1'b0;
    case (sel)
      `SEL_FIFO_THRESHOLD_CODE: v = thr;
      `SEL_LOCK: v = lock;
      `SEL_RDY_N: v = rdy_n;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // ---------------- serial clock domain ----------------
  logic [2:0] bit_cnt_reg;
  logic hdr_done_reg;
  logic hdr_rd_reg;
  logic hdr_burst_reg;
  logic [5:0] addr_reg;
  logic pa_idx_reg;
  logic [6:0] shift_in_reg;
  logic [7:0] tx_shift_reg;
  logic started_reg;
  logic wr_tog_reg;
  wr_word_t wr_word_reg;
  logic snap_s1_reg;
  logic snap_s2_reg;
  logic snap_ack_reg;
  snap_t mirror_reg;
  // core-side snapshot and its toggle, declared here since the serial side reads them
  snap_t snap_reg;
  logic snap_tog_reg;
  logic byte_done;
  logic [7:0] in_byte;
  logic [5:0] nxt_addr;
  logic nxt_pa;

  assign byte_done = (bit_cnt_reg == 3'h7);
  assign in_byte = {shift_in_reg, si};
  // burst walks the address, except in the power table where it walks the entry
  assign nxt_addr = (hdr_burst_reg && addr_reg != `A_PA_TABLE) ? 6'(addr_reg + 6'h01) : addr_reg;
  assign nxt_pa = (hdr_burst_reg && addr_reg == `A_PA_TABLE) ? ~pa_idx_reg : pa_idx_reg;

  // frame state, cleared by the frame's own chip select since sclk stops between frames
  always_ff @(posedge sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      bit_cnt_reg <= 3'h0;
      hdr_done_reg <= 1'b0;
      hdr_rd_reg <= 1'b0;
      hdr_burst_reg <= 1'b0;
      addr_reg <= 6'h00;
      pa_idx_reg <= 1'b0;
      shift_in_reg <= 7'h00;
      tx_shift_reg <= 8'h00;
      started_reg <= 1'b0;
    end
    else
    begin
      started_reg <= 1'b1;
      bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
      shift_in_reg <= in_byte[6:0];
      if (byte_done && !hdr_done_reg)
      begin
        hdr_done_reg <= 1'b1;
        hdr_rd_reg <= in_byte[`HDR_RW_BIT];
        hdr_burst_reg <= in_byte[`HDR_BURST_BIT];
        addr_reg <= in_byte[5:0];
        tx_shift_reg <= in_byte[`HDR_RW_BIT] ? read_byte(mirror_reg, in_byte[5:0], 1'b0)
                                              : mirror_reg.status;
      end
      else if (byte_done)
      begin
        addr_reg <= nxt_addr;
        pa_idx_reg <= nxt_pa;
        tx_shift_reg <= hdr_rd_reg ? read_byte(mirror_reg, nxt_addr, nxt_pa) : mirror_reg.status;
      end
      else if (!started_reg)
        tx_shift_reg <= {mirror_reg.status[6:0], 1'b0}; // status msb was shown before the first edge
      else
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  // write events: word held stable, toggle announces it
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_tog_reg <= 1'b0;
      wr_word_reg <= '0;
    end
    else if (byte_done && !hdr_done_reg && in_byte[5:0] >= `A_STROBE_MIN && in_byte[5:0] <= `A_STROBE_MAX)
    begin
      wr_word_reg <= '{is_strobe: 1'b1, addr: in_byte[5:0], data: 8'h00, pa_idx: 1'b0};
      wr_tog_reg <= ~wr_tog_reg;
    end
    else if (byte_done && hdr_done_reg && !hdr_rd_reg)
    begin
      wr_word_reg <= '{is_strobe: 1'b0, addr: addr_reg, data: in_byte, pa_idx: pa_idx_reg};
      wr_tog_reg <= ~wr_tog_reg;
    end
  end

  // readable image taken over by handshake; it is refreshed only while sclk runs
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      snap_s1_reg <= 1'b0;
      snap_s2_reg <= 1'b0;
      snap_ack_reg <= 1'b0;
      mirror_reg <= '0;
    end
    else
    begin
      snap_s1_reg <= snap_tog_reg;
      snap_s2_reg <= snap_s1_reg;
      if (snap_s2_reg != snap_ack_reg)
      begin
        mirror_reg <= snap_reg;
        snap_ack_reg <= snap_s2_reg;
      end
    end
  end

  // ---------------- core clock domain ----------------
  logic [1:0] cs_sync_reg;
  logic [1:0] lock_sync_reg;
  logic [1:0] wr_sync_reg;
  logic [1:0] ack_sync_reg;
  logic [1:0] bit_sync_reg;
  logic [1:0] start_sync_reg;
  logic [5:0] code_s1_reg;
  logic [5:0] code_s2_reg;
  logic wr_seen_reg;
  logic wr_ev;
  logic cs_n;
  logic lock;
  cfg_t cfg_reg;
  radio_state_t state_reg;
  logic cal_to_tx_reg;
  logic pd_pending_reg;
  logic [14:0] cal_cnt_reg;
  logic [7:0] wake_cnt_reg;
  logic [1:0] end_cnt_reg;
  logic [5:0] cal_result_reg;
  logic rdy_n_reg;
  logic thr_flag_reg;
  logic [6:0] thr_bytes;
  logic [11:0] step;
  logic [19:0] ch_off;
  logic enter_sleep;
  logic auto_end_cal;
  logic [3:0] fifo_free;

  assign cs_n = cs_sync_reg[1];
  assign lock = lock_sync_reg[1];
  assign wr_ev = (wr_sync_reg[1] != wr_seen_reg);
  assign enter_sleep = (state_reg == st_idle) && pd_pending_reg && cs_n;
  assign auto_end_cal = (cfg_reg.auto_cal == `AC_ON_END) ||
                        (cfg_reg.auto_cal == `AC_EVERY4 && end_cnt_reg == 2'h3);
  assign thr_bytes = `THR_BASE - {1'b0, cfg_reg.fifo_threshold_code, 2'b00};
  assign step = 12'({3'h0, 9'(9'h100 + {1'b0, cfg_reg.mantissa})} << cfg_reg.exponent);
  assign ch_off = {12'h000, cfg_reg.channel_index} * {8'h00, step};
  assign fifo_free = (fifo_count > 7'h31) ? 4'(7'h40 - fifo_count) : 4'hF;

  // two-flop synchronisers for select, lock, calibration code and the serial side's toggles, start flag and output bit
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cs_sync_reg <= 2'b11;
      lock_sync_reg <= 2'b00;
      wr_sync_reg <= 2'b00;
      ack_sync_reg <= 2'b00;
      bit_sync_reg <= 2'b00;
      start_sync_reg <= 2'b00;
      code_s1_reg <= 6'h00;
      code_s2_reg <= 6'h00;
      wr_seen_reg <= 1'b0;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[0], chip_select_n};
      lock_sync_reg <= {lock_sync_reg[0], pll_lock};
      wr_sync_reg <= {wr_sync_reg[0], wr_tog_reg};
      ack_sync_reg <= {ack_sync_reg[0], snap_ack_reg};
      bit_sync_reg <= {bit_sync_reg[0], tx_shift_reg[7]};
      start_sync_reg <= {start_sync_reg[0], started_reg};
      code_s1_reg <= vco_cal_code;
      code_s2_reg <= code_s1_reg;
      wr_seen_reg <= wr_sync_reg[1];
    end
  end

  // configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cfg_reg <= '0;
      cfg_reg.pin_cfg <= {3{`PIN_CFG_RST}};
      cfg_reg.pa_table[0] <= `PA0_RST;
    end
    else if (enter_sleep)
      cfg_reg.pa_table[1] <= 8'h00;
    else if (wr_ev && !wr_word_reg.is_strobe)
    begin
      case (wr_word_reg.addr)
        `A_PIN_CFG0: cfg_reg.pin_cfg[0] <= wr_word_reg.data[6:0];
        `A_PIN_CFG1: cfg_reg.pin_cfg[1] <= wr_word_reg.data[6:0];
        `A_PIN_CFG2: cfg_reg.pin_cfg[2] <= wr_word_reg.data[6:0];
        `A_FIFO_THRESHOLD_CODE: cfg_reg.fifo_threshold_code <= wr_word_reg.data[3:0];
        `A_CHANNEL_INDEX: cfg_reg.channel_index <= wr_word_reg.data;
        `A_SYNTH_CTRL: cfg_reg.if_field <= wr_word_reg.data[`IF_MSB:0];
        `A_FREQ_HI: cfg_reg.base_freq[23:16] <= wr_word_reg.data;
        `A_FREQ_MID: cfg_reg.base_freq[15:8] <= wr_word_reg.data;
        `A_FREQ_LO: cfg_reg.base_freq[7:0] <= wr_word_reg.data;
        `A_MDM_HI: cfg_reg.exponent <= wr_word_reg.data[`EXP_MSB:0];
        `A_MDM_LO: cfg_reg.mantissa <= wr_word_reg.data;
        `A_SM_CFG: cfg_reg.auto_cal <= wr_word_reg.data[`AUTOCAL_LSB+1:`AUTOCAL_LSB];
        `A_FRONT_END: cfg_reg.pa_sel <= wr_word_reg.data[`PA_SEL_MSB:0];
        `A_PA_TABLE: cfg_reg.pa_table[wr_word_reg.pa_idx] <= wr_word_reg.data;
        default: ;
      endcase
    end
  end

  // radio controller: idle, calibration, synthesizer on, sleep
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_reg <= st_idle;
      cal_to_tx_reg <= 1'b0;
      pd_pending_reg <= 1'b0;
      cal_cnt_reg <= 15'h0000;
      wake_cnt_reg <= 8'h00;
      end_cnt_reg <= 2'h0;
      cal_result_reg <= `CAL_UNLOCKED;
    end
    else
    begin
      unique case (state_reg)
        st_idle:
        begin
          cal_cnt_reg <= 15'h0000;
          if (enter_sleep)
          begin
            state_reg <= st_sleep;
            pd_pending_reg <= 1'b0;
            wake_cnt_reg <= 8'h00;
          end
          else if (wr_ev && wr_word_reg.is_strobe)
          begin
            if (wr_word_reg.addr == `S_CAL)
            begin
              state_reg <= st_cal;
              cal_to_tx_reg <= 1'b0;
            end
            else if (wr_word_reg.addr == `S_TX)
            begin
              state_reg <= (cfg_reg.auto_cal == `AC_ON_START) ? st_cal : st_tx;
              cal_to_tx_reg <= 1'b1;
            end
            else if (wr_word_reg.addr == `S_PWR_DOWN)
              pd_pending_reg <= 1'b1;
          end
        end
        st_cal:
        begin
          cal_cnt_reg <= 15'(cal_cnt_reg + 15'h0001);
          if (cal_cnt_reg == 15'(CAL_CYCLES - 1))
          begin
            cal_result_reg <= lock ? code_s2_reg : `CAL_UNLOCKED;
            state_reg <= cal_to_tx_reg ? st_tx : st_idle;
          end
        end
        st_tx:
        begin
          if (wr_ev && wr_word_reg.is_strobe && wr_word_reg.addr == `S_IDLE)
            state_reg <= st_idle; // forced idle never calibrates
          else if (tx_packet_done)
          begin
            end_cnt_reg <= 2'(end_cnt_reg + 2'h1);
            state_reg <= auto_end_cal ? st_cal : st_idle;
            cal_to_tx_reg <= 1'b0;
          end
        end
        st_sleep:
        begin
          // calibration result is left alone here, valid after wake
          cal_cnt_reg <= 15'h0000;
          if (!cs_n)
          begin
            wake_cnt_reg <= 8'(wake_cnt_reg + 8'h01);
            if (wake_cnt_reg == `WAKE_CYCLES)
              state_reg <= st_idle;
          end
        end
      endcase
    end
  end
  // a calibrate strobe in any state but idle falls through untouched

  // snapshot for the serial side, reloaded once the last one was taken
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      snap_reg <= '0;
      snap_tog_reg <= 1'b0;
    end
    else if (ack_sync_reg[1] == snap_tog_reg)
    begin
      snap_reg <= '{cfg: cfg_reg, cal_result: cal_result_reg,
                    status: {rdy_n_reg, 1'b0, state_reg, fifo_free}};
      snap_tog_reg <= ~snap_tog_reg;
    end
  end

  // frequency words, threshold flag and power level
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      carrier_word <= 27'h0000000;
      if_word <= 5'h00;
      pa_setting <= 8'h00;
      thr_flag_reg <= 1'b0;
    end
    else
    begin
      // two fraction bits carry the 2^(exp-2) factor
      carrier_word <= {1'b0, cfg_reg.base_freq, 2'b00} + {7'h00, ch_off};
      if_word <= cfg_reg.if_field;
      thr_flag_reg <= (fifo_count >= thr_bytes);
      // select 1 keys the table per data bit for on-off keying
      pa_setting <= (cfg_reg.pa_sel == 3'h1) ? cfg_reg.pa_table[tx_data_bit] : cfg_reg.pa_table[0];
    end
  end

  // power, ready and serial output
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rdy_n_reg <= 1'b0;
      synth_en <= 1'b0;
      core_power_en <= 1'b1;
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end
    else
    begin
      rdy_n_reg <= (state_reg == st_sleep);
      synth_en <= (state_reg == st_cal) || (state_reg == st_tx);
      core_power_en <= (state_reg != st_sleep) || !cs_n;
      // before the first edge the pin shows readiness, then the serial stream
      so <= cs_n ? 1'b0 : (start_sync_reg[1] ? bit_sync_reg[1] : rdy_n_reg);
      so_oe_n <= cs_n;
    end
  end

  // general outputs
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_pin
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
        begin
          general_output_pin[g] <= 1'b0;
          general_output_oe_n[g] <= 1'b1;
        end
        else
        begin
          general_output_pin[g] <= pin_func(cfg_reg.pin_cfg[g][5:0], thr_flag_reg, lock, rdy_n_reg) ^
                                   cfg_reg.pin_cfg[g][`PIN_INV_BIT];
          general_output_oe_n[g] <= (cfg_reg.pin_cfg[g][5:0] == `SEL_HIZ);
        end
      end
    end
  endgenerate

endmodule

// *** logic/rf_cfg_defs.svh ***
`ifndef RF_CFG_DEFS_SVH
`define RF_CFG_DEFS_SVH

// serial header layout
`define HDR_RW_BIT 7
`define HDR_BURST_BIT 6

// register addresses on the serial port
`define A_PIN_CFG0 6'h00
`define A_PIN_CFG1 6'h01
`define A_PIN_CFG2 6'h02
`define A_FIFO_THRESHOLD_CODE 6'h03
`define A_CHANNEL_INDEX 6'h0A
`define A_SYNTH_CTRL 6'h0B
`define A_FREQ_HI 6'h0D
`define A_FREQ_MID 6'h0E
`define A_FREQ_LO 6'h0F
`define A_MDM_HI 6'h13
`define A_MDM_LO 6'h14
`define A_SM_CFG 6'h18
`define A_FRONT_END 6'h22
`define A_CAL_RESULT 6'h25
`define A_PA_TABLE 6'h3E

// command strobes
`define A_STROBE_MIN 6'h30
`define A_STROBE_MAX 6'h3D
`define S_CAL 6'h33
`define S_TX 6'h35
`define S_IDLE 6'h36
`define S_PWR_DOWN 6'h39

// field positions
`define PIN_INV_BIT 6
`define AUTOCAL_LSB 4
`define EXP_MSB 1
`define IF_MSB 4
`define PA_SEL_MSB 2

// output pin selector codes
`define SEL_FIFO_THRESHOLD_CODE 6'h02
`define SEL_LOCK 6'h0A
`define SEL_RDY_N 6'h29
`define SEL_HIZ 6'h2E

// auto calibration modes
`define AC_NEVER 2'h0
`define AC_ON_START 2'h1
`define AC_ON_END 2'h2
`define AC_EVERY4 2'h3

// reset values
`define PIN_CFG_RST 7'h2E
`define PA0_RST 8'hC6
`define CAL_UNLOCKED 6'h3F

// fifo threshold: bytes = base - step * code
`define THR_BASE 7'h3D
`define THR_STEP_SH 2

// timing counts, core clock cycles
`define CAL_CYCLES_DEF 18506
`define WAKE_CYCLES 8'h10

`endif

// *** logic/rf_cfg_pkg.sv ***
package rf_cfg_pkg;

  typedef enum logic [1:0] {st_sleep, st_idle, st_cal, st_tx} radio_state_t;

  // one write or strobe passed from the serial side
  typedef struct packed {
    logic is_strobe;
    logic [5:0] addr;
    logic [7:0] data;
    logic pa_idx;
  } wr_word_t;

  // software-writable configuration
  typedef struct packed {
    logic [2:0][6:0] pin_cfg;
    logic [3:0] fifo_threshold_code;
    logic [7:0] channel_index;
    logic [4:0] if_field;
    logic [23:0] base_freq;
    logic [1:0] exponent;
    logic [7:0] mantissa;
    logic [1:0] auto_cal;
    logic [2:0] pa_sel;
    logic [1:0][7:0] pa_table;
  } cfg_t;

  // readable image handed to the serial side
  typedef struct packed {
    cfg_t cfg;
    logic [5:0] cal_result;
    logic [7:0] status;
  } snap_t;

endpackage

// *** dv/rf_cfg_chk.sv ***
`timescale 1ns/1ps
module rf_cfg_chk
  import rf_cfg_pkg::*;
#(
  parameter int CAL_CYCLES = 20
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // serial port
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  // radio side
  input wire logic pll_lock,
  input wire logic [5:0] vco_cal_code,
  input wire logic [6:0] fifo_count,
  input wire logic tx_packet_done,
  input wire logic tx_data_bit,
  input wire logic [26:0] carrier_word,
  input wire logic [4:0] if_word,
  input wire logic [7:0] pa_setting,
  input wire logic synth_en,
  input wire logic core_power_en,
  // general outputs
  input wire logic [2:0] general_output_pin,
  input wire logic [2:0] general_output_oe_n
);
  // everything here lives in the core domain
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  reset_val_a: assert property ($rose(nrst) |-> so_oe_n && !synth_en && core_power_en && general_output_oe_n == 3'h7)
    else $error("outputs not at reset level");
  pa_default_a: assert property ($rose(nrst) ##1 1'b1 |=> pa_setting == 8'hC6)
    else $error("power entry 0 not at default");
  // select low must keep the core powered
  cs_wake_a: assert property (!chip_select_n [*5] |-> core_power_en)
    else $error("core unpowered with select low");
  sleep_cause_a: assert property ($fell(core_power_en) |-> chip_select_n && $past(chip_select_n, 2))
    else $error("power removed while selected");
  synth_pwr_a: assert property (synth_en |-> core_power_en)
    else $error("synthesizer on while asleep");
  oe_idle_a: assert property (chip_select_n [*5] |-> so_oe_n)
    else $error("serial output driven while deselected");
  oe_frame_a: assert property ($fell(so_oe_n) |-> !$past(chip_select_n, 2))
    else $error("serial output driven without select");
  // wake must end with chip ready shown low
  ready_a: assert property ($rose(core_power_en) |-> ##[1:40] (!so_oe_n && !so))
    else $error("chip ready not shown after wake");
  synth_start_a: assert property ($rose(synth_en) |-> core_power_en && !$past(chip_select_n))
    else $error("synthesizer started without a strobe");
endmodule

bind radio_freq_power_config rf_cfg_chk #(.CAL_CYCLES(CAL_CYCLES)) i_rf_cfg_chk (
  .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so(so),
  .so_oe_n(so_oe_n), .pll_lock(pll_lock), .vco_cal_code(vco_cal_code), .fifo_count(fifo_count),
  .tx_packet_done(tx_packet_done), .tx_data_bit(tx_data_bit), .carrier_word(carrier_word),
  .if_word(if_word), .pa_setting(pa_setting), .synth_en(synth_en), .core_power_en(core_power_en),
  .general_output_pin(general_output_pin), .general_output_oe_n(general_output_oe_n)
);

// *** dv/spi_host.sv ***
`timescale 1ns/1ps
module spi_host
  import rf_cfg_pkg::*;
(
  // lines toward the device
  output logic sclk,
  output logic chip_select_n,
  output logic si,
  // answer from the device
  input wire logic so,
  input wire logic so_oe_n
);
  // mode 0 idle: clock low and still, deselected
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    si = 1'b0;
  end

  // one frame of nb bytes from the top of d; rd keeps the last eight bits seen
  task automatic frame(input logic [23:0] d, input int nb, output logic [7:0] rd);
    int w;
    begin
      w = 0;
      rd = 8'h00;
      chip_select_n = 1'b0;
      // no clock edge until chip ready is low
      while ((so_oe_n !== 1'b0 || so !== 1'b0) && w < 200)
      begin
        #4;
        w++;
      end
      for (int i = 0; i < 8 * nb; i++)
      begin
        si = d[23 - i];
        #15 sclk = 1'b1;
        rd = {rd[6:0], so};
        #15 sclk = 1'b0;
      end
      // hold select so the last byte lands before release
      #60 chip_select_n = 1'b1;
      si = ~si;
      #60;
    end
  endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "rf_cfg_defs.svh"
module tb
  import rf_cfg_pkg::*;
;
  localparam int CAL_N = 20;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, chip_select_n, si, so, so_oe_n, pll_lock, tx_packet_done, tx_data_bit, synth_en, core_power_en;
  logic [5:0] vco_cal_code;
  logic [6:0] fifo_count;
  logic [26:0] carrier_word;
  logic [4:0] if_word;
  logic [7:0] pa_setting, rd;
  logic [2:0] general_output_pin, general_output_oe_n;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int run = 0;
  int last_run = 0;

  always #2 core_clk = ~core_clk;

  radio_freq_power_config #(.CAL_CYCLES(CAL_N)) i_radio_freq_power_config (
    .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .pll_lock(pll_lock), .vco_cal_code(vco_cal_code), .fifo_count(fifo_count),
    .tx_packet_done(tx_packet_done), .tx_data_bit(tx_data_bit), .carrier_word(carrier_word),
    .if_word(if_word), .pa_setting(pa_setting), .synth_en(synth_en), .core_power_en(core_power_en),
    .general_output_pin(general_output_pin), .general_output_oe_n(general_output_oe_n));
  spi_host i_spi_host (.sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so(so), .so_oe_n(so_oe_n));

  task automatic check(input logic [26:0] seen, input logic [26:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_spi_host.frame({2'b00, a, d, 8'h00}, 2, rd);
  endtask

  task automatic strobe(input logic [5:0] a);
    i_spi_host.frame({2'b00, a, 16'h0000}, 1, rd);
  endtask

  // read mirror refreshes only on serial activity: first read is a dummy
  task automatic rdreg(input logic [5:0] a);
    i_spi_host.frame({2'b10, a, 16'h0000}, 2, rd);
    i_spi_host.frame({2'b10, a, 16'h0000}, 2, rd);
  endtask

  // frequency words are only touched while idle
  task automatic freq_case(input logic [23:0] b, input logic [7:0] c, input logic [7:0] m, input logic [1:0] e,
                           input logic [4:0] f);
    logic [26:0] w;
    begin
      w = {b, 2'b00} + ((27'(c) * (27'h100 + 27'(m))) << e);
      wr(`A_FREQ_HI, b[23:16]);
      wr(`A_FREQ_MID, b[15:8]);
      wr(`A_FREQ_LO, b[7:0]);
      wr(`A_CHANNEL_INDEX, c);
      wr(`A_MDM_LO, m);
      wr(`A_MDM_HI, 8'(e));
      wr(`A_SYNTH_CTRL, 8'(f));
      cyc_wait(4);
      check(carrier_word, w);
      check(27'(if_word), 27'(f));
    end
  endtask

  // hang guard and synthesizer run length
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    run <= synth_en ? run + 1 : 0;
    if (!synth_en && run != 0)
      last_run <= run;
    if (cyc == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    pll_lock = 1'b1;
    vco_cal_code = 6'h15;
    fifo_count = 7'h00;
    tx_packet_done = 1'b0;
    tx_data_bit = 1'b0;
    cyc_wait(4);
    nrst = 1'b1;
    cyc_wait(12);
    check(27'(pa_setting), 27'hC6);
    // threshold flag at every code, one byte below and at the threshold
    wr(`A_PIN_CFG0, 8'h02);
    for (int c = 0; c < 16; c++)
    begin
      wr(`A_FIFO_THRESHOLD_CODE, 8'(c));
      for (int k = 0; k < 2; k++)
      begin
        fifo_count = 7'(60 - 4 * c + k);
        cyc_wait(4);
        check(27'({general_output_oe_n[0], general_output_pin[0]}), 27'(k));
      end
    end
    // third pin shows chip ready, inverted: awake gives a high pin
    wr(`A_PIN_CFG2, 8'h69);
    cyc_wait(4);
    check(27'({general_output_oe_n[2], general_output_pin[2]}), 27'h1);
    freq_case(24'h10B071, 8'h05, 8'hF8, 2'h2, 5'h06);
    freq_case(24'hFFFFFF, 8'hFF, 8'hFF, 2'h3, 5'h1F);
    // manual calibration right after power-up
    wr(`A_SM_CFG, 8'h00);
    strobe(`S_CAL);
    check(27'(last_run >= CAL_N && last_run <= CAL_N + 2), 27'h1);
    rdreg(`A_CAL_RESULT);
    check(27'(rd), 27'h15);
    wr(`A_PIN_CFG1, 8'h0A);
    for (int k = 0; k < 2; k++)
    begin
      cyc_wait(1);
      pll_lock = k[0];
      cyc_wait(5);
      check(27'({general_output_oe_n[1], general_output_pin[1]}), 27'(k));
    end
    cyc_wait(1);
    pll_lock = 1'b0;
    strobe(`S_CAL);
    rdreg(`A_CAL_RESULT);
    check(27'(rd), 27'h3F);
    cyc_wait(1);
    pll_lock = 1'b1;
    for (int t = 0; t < 3 && rd == 8'h3F; t++)
    begin
      strobe(`S_CAL);
      rdreg(`A_CAL_RESULT);
    end
    check(27'(rd), 27'h15);
    // strobe during transmit must not recalibrate
    strobe(`S_TX);
    cyc_wait(1);
    vco_cal_code = 6'h2A;
    strobe(`S_CAL);
    strobe(`S_IDLE);
    rdreg(`A_CAL_RESULT);
    check(27'(rd), 27'h15);
    // automatic calibration on start, then on automatic end
    for (int m = 1; m < 3; m++)
    begin
      wr(`A_SM_CFG, 8'(m << 4));
      cyc_wait(1);
      vco_cal_code = 6'(m);
      strobe(`S_TX);
      cyc_wait(1);
      tx_packet_done = (m == 2);
      cyc_wait(1);
      tx_packet_done = 1'b0;
      cyc_wait(3 * CAL_N);
      strobe(`S_IDLE);
      rdreg(`A_CAL_RESULT);
      check(27'(rd), 27'(m));
    end
    // burst fills both entries; keyed then fixed selection
    i_spi_host.frame({2'b01, `A_PA_TABLE, 8'h50, 8'hC0}, 3, rd);
    for (int s = 0; s < 4; s++)
    begin
      wr(`A_FRONT_END, 8'(s < 2));
      cyc_wait(1);
      tx_data_bit = s[0];
      cyc_wait(4);
      check(27'(pa_setting), (s == 1) ? 27'hC0 : 27'h50);
    end
    wr(`A_FRONT_END, 8'h01);
    strobe(`S_PWR_DOWN);
    cyc_wait(8);
    check(27'(core_power_en), 27'h0);
    rdreg(`A_CAL_RESULT);
    check(27'(rd), 27'h02);
    check(27'(pa_setting), 27'h00);
    tx_data_bit = 1'b0;
    cyc_wait(4);
    check(27'(pa_setting), 27'h50);
    summarize();
  end
endmodule
